// [nlfc_pkg.sv]
// package: fuse, lock, signature and page geometry constants
package nlfc_pkg;
   localparam logic [7:0] LOCK_RESET = 8'hFF;
   localparam logic [7:0] EXT_FUSE_RESET = 8'hFF;
   localparam logic [7:0] HIGH_FUSE_RESET = 8'hDF;
   localparam logic [7:0] LOW_FUSE_RESET = 8'h62;
   localparam int LOCK_BIT_LOW_POS = 0;
   localparam int LOCK_BIT_HIGH_POS = 1;
   localparam int SELF_PROG_POS = 0;
   localparam int RESET_DISABLE_POS = 7;
   localparam int DEBUG_ENABLE_POS = 6;
   localparam int SERIAL_PROG_POS = 5;
   localparam int WATCHDOG_ON_POS = 4;
   localparam int EEPROM_PRESERVE_POS = 3;
   localparam int CLOCK_DIV_POS = 7;
   localparam int CLOCK_OUT_POS = 6;
   localparam int SIG_ADDR_ID0 = 0;
   localparam int SIG_ADDR_ID1 = 1;
   localparam int SIG_ADDR_ID2 = 2;
   localparam int PAGE_WORD_BITS = 6;
   localparam int PC_TOP_BIT = 12;
   localparam int EE_PAGE_BYTE_BITS = 2;
   localparam int EE_TOP_BIT = 8;
   localparam int ERASE_CYCLES = 4;
   // identity codes below are arbitrary
   localparam logic [7:0] ID_BYTE0 = 8'hA5;
   localparam logic [7:0] ID_BYTE1 = 8'h5A;
   localparam logic [7:0] ID_BYTE2 = 8'h3C;
   localparam logic [7:0] CAL_DEFAULT = 8'h80;
   typedef enum logic [1:0] {SEL_LOCK, SEL_EXT, SEL_HIGH, SEL_LOW} nlfc_sel_type;
   typedef enum {ER_IDLE, ER_FLASH, ER_LOCK} nlfc_erase_type;
endpackage

// [nlfc_byte_reg.sv]
// one non-volatile byte cell with masked programming
`timescale 1ns/1ps
`default_nettype none
module nlfc_byte_reg
   import nlfc_pkg::*;
#(
   parameter logic [7:0] INIT = 8'hFF
) (
   input wire logic clk, // system clock
   input wire logic rst, // sync reset
   input wire logic wr, // write strobe
   input wire logic [7:0] wdata, // new value
   input wire logic [7:0] wmask, // bits that may change
   output logic [7:0] q // stored byte
);
   logic [7:0] next_q;
   // masked write
   always_comb begin
      next_q = q;
      if (wr) begin
         next_q = (q & ~wmask) | (wdata & wmask);
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= INIT;
      end else begin
         q <= next_q;
      end
   end
endmodule
`default_nettype wire

// [nlfc_geometry.sv]
// flash and eeprom page address split
`timescale 1ns/1ps
`default_nettype none
module nlfc_geometry
   import nlfc_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic [PC_TOP_BIT:0] pc, // flash word address
   input wire logic [EE_TOP_BIT:0] ee_addr, // eeprom byte address
   output logic [PAGE_WORD_BITS-1:0] word_idx, // word within page
   output logic [PC_TOP_BIT-PAGE_WORD_BITS:0] page_idx, // flash page
   output logic [EE_PAGE_BYTE_BITS-1:0] ee_byte_idx, // byte within page
   output logic [EE_TOP_BIT-EE_PAGE_BYTE_BITS:0] ee_page_idx // eeprom page
);
   // registered split of both addresses
   always_ff @(posedge clk) begin
      word_idx <= pc[PAGE_WORD_BITS-1:0]; // see [RL19]
      page_idx <= pc[PC_TOP_BIT:PAGE_WORD_BITS]; // see [RL19]
      ee_byte_idx <= ee_addr[EE_PAGE_BYTE_BITS-1:0]; // see [RL20]
      ee_page_idx <= ee_addr[EE_TOP_BIT:EE_PAGE_BYTE_BITS]; // see [RL20]
   end
endmodule
`default_nettype wire

// [nlfc_config_store.sv]
// lock, fuse, signature and calibration store
// Notes on behaviour
// [RL1] lock byte bits 1,0; all reset to 1; writing 0 programs
// [RL2] lock bits return to 1 only through chip erase
// [RL3] mode 1, both bits 1: no locking
// [RL4] mode 2: no flash/eeprom programming, fuses locked; reads allowed
// [RL5] mode 3: no programming, no readout, fuses locked
// [RL6] programmer should write fuses before lock bits
// [RL7] self-program allowed over all flash only when extended bit 0 is 0
// [RL8] programmed fuse reads 0, unprogrammed reads 1
// [RL9] high fuse fields; serial enable defaults programmed
// [RL10] low fuse fields; defaults give divide-by-8 and 8 MHz RC
// [RL11] serial enable fuse unreadable and unwritable in serial mode
// [RL12] clock output fuse programmed drives system clock on port B5
// [RL13] fuses latched on programming entry; writes act after exit
// [RL14] eeprom preserve fuse acts immediately when programmed
// [RL15] fuses also latched at power-up in normal mode
// [RL16] eeprom preserve programmed keeps eeprom through chip erase
// [RL17] three id bytes at signature 0..2, readable even locked
// [RL18] calibration byte copied to calibration register during reset
// [RL19] flash pages 64 words, pc split word/page
// [RL20] eeprom 128 pages of 4 bytes
// [RL21] chip erase clears flash, eeprom, then locks; fuses kept
// [RL22] lock combination 0/1 treated as strictest mode
`timescale 1ns/1ps
`default_nettype none
module nlfc_config_store
   import nlfc_pkg::*;
(
   input wire logic SYS_CLK, // 25 MHz clock
   input wire logic SRST, // sync reset, high
   input wire logic PROG_MODE, // programming mode active
   input wire logic SERIAL_MODE, // programming over serial port
   input wire logic WR_EN, // write strobe from programmer
   input wire logic [1:0] WR_SEL, // target byte select
   input wire logic [7:0] WR_DATA, // byte to program
   input wire logic [1:0] RD_SEL, // byte to read back
   output logic [7:0] RD_DATA, // read back value
   input wire logic [1:0] SIG_ADDR, // signature address
   input wire logic SIG_HIGH, // high byte of signature word
   output logic [7:0] SIG_DATA, // signature read value
   input wire logic ERASE_REQ, // chip erase start pulse
   input wire logic FLASH_ERASE_DONE, // flash erase finished
   output logic ERASE_FLASH, // erase flash strobe
   output logic ERASE_EEPROM, // erase eeprom strobe
   output logic ERASE_BUSY, // chip erase in progress
   output logic PROG_ALLOW, // flash/eeprom programming permitted
   output logic VERIFY_ALLOW, // flash/eeprom readout permitted
   output logic FUSE_ALLOW, // fuse writes permitted
   output logic SELF_PROG_ALLOW, // self program instruction allowed
   output logic [7:0] EXT_ACTIVE, // latched extended fuses
   output logic [7:0] HIGH_ACTIVE, // latched high fuses
   output logic [7:0] LOW_ACTIVE, // latched low fuses
   output logic EEPROM_PRESERVE, // preserve fuse in effect
   output logic CLOCK_OUT_EN, // drive clock on port B5
   output logic [7:0] OSC_CAL, // calibration register
   input wire logic [PC_TOP_BIT:0] PC_IN, // flash word address
   input wire logic [EE_TOP_BIT:0] EE_ADDR, // eeprom address
   output logic [PAGE_WORD_BITS-1:0] WORD_IDX, // word in page
   output logic [PC_TOP_BIT-PAGE_WORD_BITS:0] PAGE_IDX, // flash page
   output logic [EE_PAGE_BYTE_BITS-1:0] EE_BYTE_IDX, // eeprom byte in page
   output logic [EE_TOP_BIT-EE_PAGE_BYTE_BITS:0] EE_PAGE_IDX // eeprom page
);
   localparam logic [7:0] NO_BITS = 8'h00;
   localparam logic [7:0] ALL_BITS = 8'hFF;
   localparam logic [7:0] SERIAL_BIT = 8'h20;
   localparam logic [7:0] LOCK_MASK = 8'h03;
   logic [7:0] lock_byte;
   logic [7:0] extended_fuse_byte;
   logic [7:0] high_fuse_byte;
   logic [7:0] low_fuse_byte;
   logic [7:0] next_ext_act, next_high_act, next_low_act;
   logic [7:0] lock_mask, ext_mask, high_mask, low_mask;
   logic lock_wr, ext_wr, high_wr, low_wr;
   logic lock_clear, mode_unlocked, mode_prog_block, mode_read_block;
   logic prog_mode_q, cal_load;
   logic [7:0] cal_byte;
   nlfc_erase_type erase_state, next_erase_state;
   logic next_prog_mode_q;
   logic [7:0] next_osc_cal;
   logic next_cal_load;
   logic [7:0] next_lock_byte;

   // protection mode decode
   always_comb begin
      mode_unlocked = lock_byte[LOCK_BIT_HIGH_POS] & lock_byte[LOCK_BIT_LOW_POS]; // see [RL3]
      mode_prog_block = ~mode_unlocked; // see [RL4]
      mode_read_block = ~lock_byte[LOCK_BIT_HIGH_POS]; // see [RL5] see [RL22]
   end
   assign PROG_ALLOW = mode_unlocked & ~ERASE_BUSY; // see [RL4]
   assign VERIFY_ALLOW = ~mode_read_block; // see [RL5]
   assign FUSE_ALLOW = mode_unlocked; // see [RL4] see [RL5]
   assign SELF_PROG_ALLOW = ~EXT_ACTIVE[SELF_PROG_POS]; // see [RL7]

   // write decode and permitted bit masks
   always_comb begin
      lock_wr = WR_EN & (WR_SEL == SEL_LOCK);
      ext_wr = WR_EN & (WR_SEL == SEL_EXT) & FUSE_ALLOW;
      high_wr = WR_EN & (WR_SEL == SEL_HIGH) & FUSE_ALLOW;
      low_wr = WR_EN & (WR_SEL == SEL_LOW) & FUSE_ALLOW;
      // writes can only program (clear) lock bits
      lock_mask = LOCK_MASK & ~WR_DATA; // see [RL1] see [RL2]
      ext_mask = ALL_BITS;
      high_mask = SERIAL_MODE ? ~SERIAL_BIT : ALL_BITS; // see [RL11]
      low_mask = ALL_BITS;
      lock_clear = (erase_state == ER_LOCK); // see [RL2] see [RL21]
   end

   // lock next value: erase sets bits, writes clear them
   always_comb begin
      next_lock_byte = lock_byte;
      if (lock_clear) begin
         next_lock_byte = lock_byte | LOCK_MASK; // see [RL2]
      end else if (lock_wr) begin
         next_lock_byte = lock_byte & ~lock_mask; // see [RL1]
      end
   end
   // the lock cell
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         lock_byte <= LOCK_RESET; // see [RL1]
      end else begin
         lock_byte <= next_lock_byte;
      end
   end

   nlfc_byte_reg #(.INIT(EXT_FUSE_RESET)) u_ext (
      .clk(SYS_CLK), .rst(SRST), .wr(ext_wr), .wdata(WR_DATA),
      .wmask(ext_mask), .q(extended_fuse_byte)
   );
   nlfc_byte_reg #(.INIT(HIGH_FUSE_RESET)) u_high (
      .clk(SYS_CLK), .rst(SRST), .wr(high_wr), .wdata(WR_DATA),
      .wmask(high_mask), .q(high_fuse_byte) // see [RL9]
   );
   nlfc_byte_reg #(.INIT(LOW_FUSE_RESET)) u_low (
      .clk(SYS_CLK), .rst(SRST), .wr(low_wr), .wdata(WR_DATA),
      .wmask(low_mask), .q(low_fuse_byte) // see [RL10]
   );

   // working latches load on programming entry, on exit and at power-up
   always_comb begin
      next_prog_mode_q = PROG_MODE;
      next_ext_act = EXT_ACTIVE;
      next_high_act = HIGH_ACTIVE;
      next_low_act = LOW_ACTIVE;
      if (PROG_MODE != prog_mode_q) begin
         next_ext_act = extended_fuse_byte; // see [RL13]
         next_high_act = high_fuse_byte; // see [RL13]
         next_low_act = low_fuse_byte; // see [RL13]
      end
   end
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         prog_mode_q <= 1'b0;
         EXT_ACTIVE <= EXT_FUSE_RESET; // see [RL15]
         HIGH_ACTIVE <= HIGH_FUSE_RESET; // see [RL15]
         LOW_ACTIVE <= LOW_FUSE_RESET; // see [RL15]
      end else begin
         prog_mode_q <= next_prog_mode_q;
         EXT_ACTIVE <= next_ext_act;
         HIGH_ACTIVE <= next_high_act;
         LOW_ACTIVE <= next_low_act;
      end
   end
   // preserve fuse bypasses the latch
   assign EEPROM_PRESERVE = ~high_fuse_byte[EEPROM_PRESERVE_POS]; // see [RL14] see [RL16]
   assign CLOCK_OUT_EN = ~LOW_ACTIVE[CLOCK_OUT_POS]; // see [RL12]

   // read back of lock and fuse bytes, programmed reads 0
   always_comb begin
      unique case (nlfc_sel_type'(RD_SEL))
         SEL_LOCK: RD_DATA = lock_byte; // see [RL8]
         SEL_EXT: RD_DATA = extended_fuse_byte;
         SEL_HIGH: RD_DATA = SERIAL_MODE ? (high_fuse_byte | SERIAL_BIT) : high_fuse_byte; // see [RL11]
         SEL_LOW: RD_DATA = low_fuse_byte;
      endcase
   end

   // signature space, independent of locking
   always_comb begin
      cal_byte = CAL_DEFAULT;
      if (SIG_HIGH) begin
         SIG_DATA = (SIG_ADDR == 2'(SIG_ADDR_ID0)) ? cal_byte : ALL_BITS; // see [RL18]
      end else begin
         unique case (SIG_ADDR)
            2'(SIG_ADDR_ID0): SIG_DATA = ID_BYTE0; // see [RL17]
            2'(SIG_ADDR_ID1): SIG_DATA = ID_BYTE1; // see [RL17]
            2'(SIG_ADDR_ID2): SIG_DATA = ID_BYTE2; // see [RL17]
            default: SIG_DATA = ALL_BITS;
         endcase
      end
   end

   // calibration copy during reset
   always_comb begin
      next_cal_load = SRST;
      next_osc_cal = cal_load ? cal_byte : OSC_CAL;
   end
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         OSC_CAL <= CAL_DEFAULT; // see [RL18]
         cal_load <= 1'b1;
      end else begin
         OSC_CAL <= next_osc_cal;
         cal_load <= next_cal_load;
      end
   end

   // chip erase sequence: flash first, lock bits after
   always_comb begin
      next_erase_state = erase_state;
      unique case (erase_state)
         ER_IDLE: if (ERASE_REQ) next_erase_state = ER_FLASH;
         ER_FLASH: if (FLASH_ERASE_DONE) next_erase_state = ER_LOCK; // see [RL21]
         ER_LOCK: next_erase_state = ER_IDLE;
      endcase
   end
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         erase_state <= ER_IDLE;
      end else begin
         erase_state <= next_erase_state;
      end
   end
   assign ERASE_BUSY = (erase_state != ER_IDLE);
   assign ERASE_FLASH = (erase_state == ER_IDLE) & ERASE_REQ; // see [RL21]
   assign ERASE_EEPROM = (erase_state == ER_IDLE) & ERASE_REQ & ~EEPROM_PRESERVE; // see [RL16]

   nlfc_geometry u_geo (
      .clk(SYS_CLK), .pc(PC_IN), .ee_addr(EE_ADDR),
      .word_idx(WORD_IDX), .page_idx(PAGE_IDX),
      .ee_byte_idx(EE_BYTE_IDX), .ee_page_idx(EE_PAGE_IDX)
   );

   // checks on lock programming and chip erase
   chk_lock_erase_only: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL2]
      (erase_state != ER_LOCK) |=> ((lock_byte & LOCK_MASK) & ~$past(lock_byte)) == NO_BITS)
      else $error("lock bit returned to 1 without erase");
   chk_lock_program: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL1]
      (lock_wr && !lock_clear) |=>
      ((lock_byte & LOCK_MASK) == ($past(lock_byte) & $past(WR_DATA) & LOCK_MASK)))
      else $error("lock write did not program the zero bits");
   chk_lock_upper: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL1]
      (lock_byte & ~LOCK_MASK) == (ALL_BITS & ~LOCK_MASK))
      else $error("unused lock byte bit programmed");
   chk_erase_clears: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL21]
      (erase_state == ER_LOCK) |=> (lock_byte[1:0] == 2'h3))
      else $error("erase did not clear lock bits");
   chk_erase_order: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL21]
      (erase_state == ER_FLASH && !FLASH_ERASE_DONE) |=> !lock_clear)
      else $error("lock bits reset before flash erase finished");
   chk_fuse_kept: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL21]
      (erase_state == ER_LOCK && !WR_EN) |=> $stable(high_fuse_byte) && $stable(low_fuse_byte))
      else $error("chip erase changed a fuse byte");
   chk_preserve_ee: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL16]
      EEPROM_PRESERVE |-> !ERASE_EEPROM)
      else $error("eeprom erased while preserved");

   // checks on protection modes
   chk_mode1_free: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL3]
      (lock_byte[1:0] == 2'h3 && !ERASE_BUSY) |-> PROG_ALLOW && VERIFY_ALLOW && FUSE_ALLOW)
      else $error("access blocked in mode 1");
   chk_mode2_read: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL4]
      (lock_byte[1:0] == 2'h2) |-> VERIFY_ALLOW && !PROG_ALLOW && !FUSE_ALLOW)
      else $error("wrong permissions in mode 2");
   chk_mode2_fuse: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL4]
      (!mode_unlocked && WR_EN && WR_SEL != SEL_LOCK) |=> $stable(high_fuse_byte))
      else $error("fuse changed while locked");
   chk_ext_locked: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL4]
      (!mode_unlocked && WR_EN && WR_SEL == SEL_EXT) |=> $stable(extended_fuse_byte))
      else $error("extended fuse changed while locked");
   chk_low_locked: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL5]
      (!mode_unlocked && WR_EN && WR_SEL == SEL_LOW) |=> $stable(low_fuse_byte))
      else $error("low fuse changed while locked");
   chk_mode3_read: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL5]
      (lock_byte[1:0] == 2'h0) |-> !VERIFY_ALLOW && !PROG_ALLOW)
      else $error("readout allowed in mode 3");
   chk_odd_lock: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL22]
      (lock_byte[1:0] == 2'h1) |-> !VERIFY_ALLOW && !PROG_ALLOW && !FUSE_ALLOW)
      else $error("odd lock combination not strictest");

   // checks on fuse latching, serial access and calibration
   chk_latch_hold: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL13]
      (PROG_MODE && prog_mode_q) |=> $stable(LOW_ACTIVE))
      else $error("fuse latch changed inside programming mode");
   chk_latch_load: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL13]
      (PROG_MODE != prog_mode_q) |=> (HIGH_ACTIVE == $past(high_fuse_byte)))
      else $error("fuse latch not loaded on mode change");
   chk_latch_power: assert property (@(posedge SYS_CLK) // see [RL15]
      $fell(SRST) |-> (EXT_ACTIVE == EXT_FUSE_RESET) && (HIGH_ACTIVE == HIGH_FUSE_RESET)
      && (LOW_ACTIVE == LOW_FUSE_RESET))
      else $error("fuse latches not loaded at power-up");
   chk_preserve_now: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL14]
      (high_wr && !WR_DATA[EEPROM_PRESERVE_POS]) |=> EEPROM_PRESERVE)
      else $error("preserve fuse did not act at once");
   chk_serial_hidden: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL11]
      (SERIAL_MODE && high_wr) |=> high_fuse_byte[5] == $past(high_fuse_byte[5]))
      else $error("serial enable fuse written in serial mode");
   chk_serial_read: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RL11]
      (SERIAL_MODE && RD_SEL == SEL_HIGH) |-> RD_DATA[SERIAL_PROG_POS])
      else $error("serial enable fuse visible in serial mode");
   chk_cal_copy: assert property (@(posedge SYS_CLK) // see [RL18]
      $fell(SRST) |=> (OSC_CAL == CAL_DEFAULT))
      else $error("calibration not loaded at reset");
endmodule
`default_nettype wire

// [nlfc_flash_model.sv]
// flash array stand-in that answers a chip erase with a completion pulse
`timescale 1ns/1ps
`default_nettype none
module nlfc_flash_model (
   input wire logic clk, // system clock
   input wire logic erase, // erase strobe from the store
   input wire logic [7:0] delay, // cycles the erase takes
   output logic done // one-cycle completion pulse
);
   int cnt = 0;
   // restart on each erase strobe, pulse done as the count runs out
   always @(posedge clk) begin
      done <= (cnt == 1);
      if (erase) begin
         cnt <= delay;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the lock, fuse and signature store
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import nlfc_pkg::*;
   logic clk, srst, prog, serial, wr_en, sig_high, erase_req, done;
   logic [1:0] wr_sel, rd_sel, sig_addr, ebidx;
   logic [7:0] wr_data, delay, rd_data, sig_data, ext_a, high_a, low_a, osc;
   logic er_f, er_e, busy, p_ok, v_ok, f_ok, s_ok, ee_pres, ck_out;
   logic [12:0] pc;
   logic [8:0] ee;
   logic [5:0] widx;
   logic [6:0] pidx, epidx;
   logic [7:0] m [4];
   int bad_count = 0;
   int num_checks = 0;
   nlfc_config_store dut (.SYS_CLK(clk), .SRST(srst), .PROG_MODE(prog), .SERIAL_MODE(serial),
      .WR_EN(wr_en), .WR_SEL(wr_sel), .WR_DATA(wr_data), .RD_SEL(rd_sel), .RD_DATA(rd_data),
      .SIG_ADDR(sig_addr), .SIG_HIGH(sig_high), .SIG_DATA(sig_data), .ERASE_REQ(erase_req),
      .FLASH_ERASE_DONE(done), .ERASE_FLASH(er_f), .ERASE_EEPROM(er_e), .ERASE_BUSY(busy),
      .PROG_ALLOW(p_ok), .VERIFY_ALLOW(v_ok), .FUSE_ALLOW(f_ok), .SELF_PROG_ALLOW(s_ok),
      .EXT_ACTIVE(ext_a), .HIGH_ACTIVE(high_a), .LOW_ACTIVE(low_a), .EEPROM_PRESERVE(ee_pres),
      .CLOCK_OUT_EN(ck_out), .OSC_CAL(osc), .PC_IN(pc), .EE_ADDR(ee), .WORD_IDX(widx),
      .PAGE_IDX(pidx), .EE_BYTE_IDX(ebidx), .EE_PAGE_IDX(epidx));
   nlfc_flash_model flash (.clk(clk), .erase(er_f), .delay(delay), .done(done));
   // clock generation
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // permission triple {prog, verify, fuse} from the lock bits
   function automatic logic [2:0] modes(input logic [1:0] lb);
      case (lb)
         2'b11: return 3'b111;
         2'b10: return 3'b010;
         default: return 3'b000;
      endcase
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      if (bad_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // write one byte and track what the store should then hold
   task automatic wr(input logic [1:0] sel, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      wr_sel <= sel;
      wr_data <= d;
      if (sel == SEL_LOCK) begin
         m[0][1:0] = m[0][1:0] & d[1:0];
      end else if (m[0][1:0] == 2'b11) begin
         m[sel] = (serial && sel == SEL_HIGH) ? ((d & 8'hDF) | (m[2] & 8'h20)) : d;
      end
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // read back all four bytes and the permission levels
   task automatic rd_all();
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         rd_sel <= s[1:0];
         #1;
         chk(rd_data, (serial && s == 2) ? (m[2] | 8'h20) : m[s]);
      end
      chk({p_ok, v_ok, f_ok}, modes(m[0][1:0]));
   endtask
   task automatic sig_check();
      logic [7:0] ids [3];
      ids = '{ID_BYTE0, ID_BYTE1, ID_BYTE2};
      for (int a = 0; a < 4; a++) begin
         @(posedge clk);
         sig_addr <= (a < 3) ? a[1:0] : 2'h0;
         sig_high <= (a == 3);
         #1;
         chk(sig_data, (a < 3) ? ids[a] : CAL_DEFAULT);
      end
   endtask
   task automatic erase(input logic exp_ee);
      @(posedge clk);
      erase_req <= 1'b1;
      #1;
      chk({er_f, er_e}, {1'b1, exp_ee});
      @(posedge clk);
      erase_req <= 1'b0;
      rd_sel <= 2'h0;
      #1;
      // busy, no programming, lock bits still as they were
      chk({busy, p_ok, rd_data}, {2'h2, m[0]});
      for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
      #1;
      chk(busy, 1'b0);
      m[0] = LOCK_RESET;
      rd_all();
   endtask
   // watchdog against a hang
   initial begin
      #(40 * 5000);
      bad_count++;
      final_report();
   end
   // main sequence
   initial begin
      {srst, prog, serial, wr_en, sig_high, erase_req} = 6'b100000;
      {wr_sel, rd_sel, sig_addr, wr_data, pc, ee} = '0;
      delay = 8'h02;
      m = '{LOCK_RESET, EXT_FUSE_RESET, HIGH_FUSE_RESET, LOW_FUSE_RESET};
      void'($urandom(52558));
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      rd_all();
      chk({ext_a, high_a, low_a}, {m[1], m[2], m[3]});
      chk({osc, s_ok, ck_out, ee_pres}, {CAL_DEFAULT, 3'h0});
      sig_check();
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         pc <= (i == 0) ? 13'h1FFF : 13'($urandom);
         ee <= (i == 0) ? 9'h1FF : 9'($urandom);
         @(posedge clk);
         #1;
         chk({widx, pidx, ebidx, epidx}, {pc[5:0], pc[12:6], ee[1:0], ee[8:2]});
      end
      @(posedge clk);
      prog <= 1'b1;
      erase(1'b1);
      // fuses go in before any lock bit
      wr(SEL_EXT, 8'($urandom) & 8'hFE);
      wr(SEL_HIGH, 8'($urandom) & 8'hF7);
      wr(SEL_LOW, 8'($urandom) & 8'hBF);
      rd_all();
      chk({ee_pres, high_a}, {1'b1, HIGH_FUSE_RESET});
      @(posedge clk);
      prog <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({ext_a, high_a, low_a}, {m[1], m[2], m[3]});
      chk({s_ok, ck_out}, 2'h3);
      @(posedge clk);
      prog <= 1'b1;
      serial <= 1'b1;
      wr(SEL_HIGH, m[2] ^ 8'h20);
      rd_all();
      @(posedge clk);
      serial <= 1'b0;
      rd_all();
      wr(SEL_LOCK, 8'hFE);
      wr(SEL_HIGH, 8'hFF);
      wr(SEL_EXT, 8'hFF);
      wr(SEL_LOCK, 8'hFF);
      rd_all();
      sig_check();
      wr(SEL_LOCK, 8'hFD);
      wr(SEL_LOW, 8'($urandom));
      rd_all();
      delay <= 8'h1E;
      erase(1'b0);
      wr(SEL_LOCK, 8'hFD);
      rd_all();
      final_report();
   end
endmodule
`default_nettype wire
